// *** charger_i2c_target.sv ***
// Purpose: two-wire target port of the charger with its first two control registers
// Assumes: master makes the clock and never stretches; lines sampled on SYS_CLK_I
// Notes: registers above 0x01 are plain storage; fault and flag ignore writes

// Functional notes
// - first byte: 7-bit address plus direction
// - direction fixed until repeated start or stop
// - first written byte loads register pointer
// - written bytes stored, pointer then advances
// - read after repeated start sends selected register
// - master ack advances read, nack ends
// - auto-increment skips fault and flag registers
// - answer only address 0x1A, sixteen registers
// - pointer above 0x0F reads 0xFF
// - registers eight bits, bit 7 MSB
// - disconnect bit isolates input supply pin
// - status pin: charge, user bits, or float
// - detection overwrites current limit code
// - bit set disables light-load modulation
// - watchdog kick set by host, hardware clears
// - boost enable beats charge enable
// - charge needs bit set and pin low
// - minimum system voltage code, reset 101
module charger_i2c_target (
  input wire logic SYS_CLK_I,
  input wire logic RST_B_I,
  charger_i2c_link_if.target LINK,
  input wire logic CHARGE_ENABLE_PIN_N_I,
  input wire logic STATUS_USER_I,
  input wire logic DETECT_DONE_I,
  input wire logic [charger_i2c_pkg::ICL_W-1:0] DETECT_ICL_CODE_I,
  input wire logic WATCHDOG_RESTART_I,
  output logic INPUT_DISCONNECT_ENABLE_O,
  output logic [1:0] STATUS_PIN_FUNCTION_SELECT_O,
  output logic [charger_i2c_pkg::ICL_W-1:0] INPUT_CURRENT_LIMIT_CODE_O,
  output logic LIGHT_LOAD_MODULATION_DISABLE_O,
  output logic WATCHDOG_KICK_O,
  output logic BOOST_OUTPUT_ENABLE_O,
  output logic CHARGE_ACTIVE_O,
  output logic [charger_i2c_pkg::SYSMIN_W-1:0] MINIMUM_SYSTEM_VOLTAGE_CODE_O,
  output logic STATUS_PIN_O,
  output logic STATUS_PIN_OE_N_O
);
  import charger_i2c_pkg::*;

  typedef enum logic [3:0] {
    ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_PTR, ST_PTR_ACK,
    ST_WDATA, ST_WDATA_ACK, ST_RDATA, ST_RACK
  } tgt_state_e;

  // ---------------------------------------------------------------
  // input synchronisers: scl, sda, charge enable pin
  // ---------------------------------------------------------------
  localparam int N_IN = 3;
  logic [N_IN-1:0] pins_raw;
  logic [N_IN-1:0] sync1_r;
  logic [N_IN-1:0] sync2_r;
  logic [N_IN-1:0] sync3_r;
  logic [N_IN-1:0] filt_r;
  logic scl_d_r;
  logic sda_d_r;

  assign pins_raw = {CHARGE_ENABLE_PIN_N_I, LINK.sda, LINK.scl};

  genvar gi;
  generate
    for (gi = 0; gi < N_IN; gi++) begin : g_sync
      always_ff @(posedge SYS_CLK_I) begin
        if (!RST_B_I) begin
          sync1_r[gi] <= 1'b1;
          sync2_r[gi] <= 1'b1;
          sync3_r[gi] <= 1'b1;
          filt_r[gi] <= 1'b1;
        end else begin
          sync1_r[gi] <= pins_raw[gi];
          sync2_r[gi] <= sync1_r[gi];
          sync3_r[gi] <= sync2_r[gi];
          // a change counts only once two stages agree
          if (sync2_r[gi] == sync3_r[gi]) begin
            filt_r[gi] <= sync3_r[gi];
          end
        end
      end
    end
  endgenerate

  always_ff @(posedge SYS_CLK_I) begin
    if (!RST_B_I) begin
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else begin
      scl_d_r <= filt_r[0];
      sda_d_r <= filt_r[1];
    end
  end

  logic scl_f;
  logic sda_f;
  logic pin_n_f;
  logic scl_rise;
  logic scl_fall;
  logic start_ev;
  logic stop_ev;
  assign scl_f = filt_r[0];
  assign sda_f = filt_r[1];
  assign pin_n_f = filt_r[2];
  assign scl_rise = scl_f & ~scl_d_r;
  assign scl_fall = ~scl_f & scl_d_r;
  assign start_ev = scl_f & scl_d_r & sda_d_r & ~sda_f;
  assign stop_ev = scl_f & scl_d_r & ~sda_d_r & sda_f;

  // ---------------------------------------------------------------
  // register storage and pointer helpers
  // ---------------------------------------------------------------
  logic [BYTE_W-1:0] regs_r [REG_COUNT];
  logic [BYTE_W-1:0] ptr_r;

  function automatic logic [BYTE_W-1:0] ptr_next(input logic [BYTE_W-1:0] p);
    logic [BYTE_W-1:0] n;
    n = p + PTR_STEP;
    if (n == FAULT_PTR || n == FLAG_PTR) begin
      n = n + PTR_STEP;
    end
    return n;
  endfunction

  function automatic logic [BYTE_W-1:0] reg_read(input logic [BYTE_W-1:0] p);
    if (p > PTR_LAST) begin
      return READ_FILL;
    end
    return regs_r[p[3:0]];
  endfunction

  // ---------------------------------------------------------------
  // bus state machine
  // ---------------------------------------------------------------
  tgt_state_e state_r;
  logic [3:0] cnt_r;
  logic [BYTE_W-1:0] shift_r;
  logic [BYTE_W-1:0] tx_r;
  logic read_dir_r;
  logic master_ack_r;
  logic sda_low_r;
  logic wr_now;
  logic [BYTE_W-1:0] rd_byte;

  assign wr_now = scl_fall && state_r == ST_WDATA && cnt_r == BYTE_BITS;
  always_comb rd_byte = reg_read(ptr_r);

  always_ff @(posedge SYS_CLK_I) begin
    if (!RST_B_I) begin
      state_r <= ST_IDLE;
      cnt_r <= 4'h0;
      shift_r <= 8'h00;
      tx_r <= 8'h00;
      read_dir_r <= 1'b0;
      master_ack_r <= 1'b0;
      sda_low_r <= 1'b0;
      ptr_r <= 8'h00;
    end else if (start_ev) begin
      state_r <= ST_ADDR;
      cnt_r <= 4'h0;
      sda_low_r <= 1'b0;
    end else if (stop_ev) begin
      state_r <= ST_IDLE;
      sda_low_r <= 1'b0;
    end else if (scl_rise) begin
      unique case (state_r)
        ST_ADDR, ST_PTR, ST_WDATA: begin
          shift_r <= {shift_r[BYTE_W-2:0], sda_f};
          cnt_r <= cnt_r + 4'h1;
        end
        ST_RDATA: cnt_r <= cnt_r + 4'h1;
        ST_RACK: begin
          master_ack_r <= ~sda_f;
          if (!sda_f) begin
            ptr_r <= ptr_next(ptr_r);
          end
        end
        default: ;
      endcase
    end else if (scl_fall) begin
      unique case (state_r)
        ST_ADDR: begin
          if (cnt_r == BYTE_BITS) begin
            if (shift_r[BYTE_W-1:1] == TARGET_ADDR) begin
              read_dir_r <= shift_r[0];
              sda_low_r <= 1'b1;
              state_r <= ST_ADDR_ACK;
            end else begin
              state_r <= ST_IDLE;
            end
          end
        end
        ST_ADDR_ACK: begin
          cnt_r <= 4'h0;
          if (read_dir_r) begin
            tx_r <= rd_byte;
            sda_low_r <= ~rd_byte[BYTE_W-1];
            state_r <= ST_RDATA;
          end else begin
            sda_low_r <= 1'b0;
            state_r <= ST_PTR;
          end
        end
        ST_PTR: begin
          if (cnt_r == BYTE_BITS) begin
            ptr_r <= shift_r;
            sda_low_r <= 1'b1;
            state_r <= ST_PTR_ACK;
          end
        end
        ST_PTR_ACK, ST_WDATA_ACK: begin
          sda_low_r <= 1'b0;
          cnt_r <= 4'h0;
          state_r <= ST_WDATA;
        end
        ST_WDATA: begin
          if (cnt_r == BYTE_BITS) begin
            ptr_r <= ptr_next(ptr_r);
            sda_low_r <= 1'b1;
            state_r <= ST_WDATA_ACK;
          end
        end
        ST_RDATA: begin
          if (cnt_r == BYTE_BITS) begin
            sda_low_r <= 1'b0;
            state_r <= ST_RACK;
          end else begin
            tx_r <= {tx_r[BYTE_W-2:0], 1'b0};
            sda_low_r <= ~tx_r[BYTE_W-2];
          end
        end
        ST_RACK: begin
          cnt_r <= 4'h0;
          if (master_ack_r) begin
            tx_r <= rd_byte;
            sda_low_r <= ~rd_byte[BYTE_W-1];
            state_r <= ST_RDATA;
          end else begin
            sda_low_r <= 1'b0;
            state_r <= ST_IDLE;
          end
        end
        default: ;
      endcase
    end
  end

  assign LINK.dev_sda_out = 1'b0;
  assign LINK.dev_sda_oe_n = ~sda_low_r;

  // ---------------------------------------------------------------
  // register file
  // ---------------------------------------------------------------
  generate
    for (gi = 0; gi < REG_COUNT; gi++) begin : g_reg
      if (gi == ISC_IDX) begin : g_isc
        always_ff @(posedge SYS_CLK_I) begin
          if (!RST_B_I) begin
            regs_r[gi] <= ISC_RESET;
          end else begin
            if (wr_now && ptr_r == BYTE_W'(gi)) begin
              regs_r[gi] <= shift_r;
            end
            // detection result wins over a host write in the same cycle
            if (DETECT_DONE_I) begin
              regs_r[gi][ICL_HI:ICL_LO] <= DETECT_ICL_CODE_I;
            end
          end
        end
      end else if (gi == PMC_IDX) begin : g_pmc
        always_ff @(posedge SYS_CLK_I) begin
          if (!RST_B_I) begin
            regs_r[gi] <= PMC_RESET;
          end else begin
            if (wr_now && ptr_r == BYTE_W'(gi)) begin
              regs_r[gi] <= shift_r;
            end
            // a restart clears the kick, but a kick written now survives it
            if (WATCHDOG_RESTART_I && !(wr_now && ptr_r == BYTE_W'(gi)
                && shift_r[KICK_BIT])) begin
              regs_r[gi][KICK_BIT] <= 1'b0;
            end
          end
        end
      end else begin : g_other
        always_ff @(posedge SYS_CLK_I) begin
          if (!RST_B_I) begin
            regs_r[gi] <= OTHER_RESET;
          end else if (wr_now && ptr_r == BYTE_W'(gi)
                       && ptr_r != FAULT_PTR && ptr_r != FLAG_PTR) begin
            regs_r[gi] <= shift_r;
          end
        end
      end
    end
  endgenerate

  // ---------------------------------------------------------------
  // control outputs
  // ---------------------------------------------------------------
  logic charge_active_r;
  logic stat_oe_n_r;
  always_ff @(posedge SYS_CLK_I) begin
    if (!RST_B_I) begin
      charge_active_r <= 1'b0;
      stat_oe_n_r <= 1'b1;
    end else begin
      charge_active_r <= regs_r[PMC_IDX][CHG_BIT] & ~pin_n_f
                         & ~regs_r[PMC_IDX][BOOST_BIT];
      unique case (regs_r[ISC_IDX][STAT_SEL_HI:STAT_SEL_LO])
        STAT_FOLLOW_CHARGE: stat_oe_n_r <= ~charge_active_r;
        STAT_FOLLOW_USER: stat_oe_n_r <= ~STATUS_USER_I;
        default: stat_oe_n_r <= 1'b1;
      endcase
    end
  end

  assign INPUT_DISCONNECT_ENABLE_O = regs_r[ISC_IDX][DISC_BIT];
  assign STATUS_PIN_FUNCTION_SELECT_O = regs_r[ISC_IDX][STAT_SEL_HI:STAT_SEL_LO];
  assign INPUT_CURRENT_LIMIT_CODE_O = regs_r[ISC_IDX][ICL_HI:ICL_LO];
  assign LIGHT_LOAD_MODULATION_DISABLE_O = regs_r[PMC_IDX][LLM_BIT];
  assign WATCHDOG_KICK_O = regs_r[PMC_IDX][KICK_BIT];
  assign BOOST_OUTPUT_ENABLE_O = regs_r[PMC_IDX][BOOST_BIT];
  assign CHARGE_ACTIVE_O = charge_active_r;
  assign MINIMUM_SYSTEM_VOLTAGE_CODE_O = regs_r[PMC_IDX][SYSMIN_HI:SYSMIN_LO];
  assign STATUS_PIN_O = 1'b0;
  assign STATUS_PIN_OE_N_O = stat_oe_n_r;
endmodule

// *** charger_i2c_pkg.sv ***
// Purpose: shared constants for the charger two-wire port and its bus master
// Assumes: 20 MHz system clock on both ends
// Notes: field positions are bit indices inside an 8-bit register
package charger_i2c_pkg;
  // ---------------------------------------------------------------
  // target side
  // ---------------------------------------------------------------
  localparam logic [6:0] TARGET_ADDR = 7'h1A;
  localparam int REG_COUNT = 16;
  localparam int BYTE_W = 8;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [7:0] PTR_LAST = 8'h0F;
  localparam logic [7:0] FAULT_PTR = 8'h09;
  localparam logic [7:0] FLAG_PTR = 8'h0E;
  localparam logic [7:0] READ_FILL = 8'hFF;
  localparam logic [7:0] PTR_STEP = 8'h01;
  localparam int ISC_IDX = 0;
  localparam int PMC_IDX = 1;
  localparam logic [7:0] ISC_RESET = 8'h17;
  localparam logic [7:0] PMC_RESET = 8'h1A;
  localparam logic [7:0] OTHER_RESET = 8'h00;
  localparam int DISC_BIT = 7;
  localparam int STAT_SEL_HI = 6;
  localparam int STAT_SEL_LO = 5;
  localparam int ICL_HI = 4;
  localparam int ICL_LO = 0;
  localparam int ICL_W = 5;
  localparam int LLM_BIT = 7;
  localparam int KICK_BIT = 6;
  localparam int BOOST_BIT = 5;
  localparam int CHG_BIT = 4;
  localparam int SYSMIN_HI = 3;
  localparam int SYSMIN_LO = 1;
  localparam int SYSMIN_W = 3;
  localparam logic [1:0] STAT_FOLLOW_CHARGE = 2'h0;
  localparam logic [1:0] STAT_FOLLOW_USER = 2'h1;
  // ---------------------------------------------------------------
  // master side
  // ---------------------------------------------------------------
  localparam int SYS_CLK_HZ = 20_000_000;
  localparam int BIT_RATE_HZ = 100_000;
  localparam int QUARTER_CYCLES = SYS_CLK_HZ / (4 * BIT_RATE_HZ);
  localparam int APB_AW = 4;
  localparam logic [APB_AW-1:0] CMD_OFS = 4'h0;
  localparam logic [APB_AW-1:0] TXD_OFS = 4'h4;
  localparam logic [APB_AW-1:0] RXD_OFS = 4'h8;
  localparam logic [APB_AW-1:0] STAT_OFS = 4'hC;
  localparam int CMD_START = 0;
  localparam int CMD_STOP = 1;
  localparam int CMD_READ = 2;
  localparam int CMD_NACK = 3;
  localparam int STAT_BUSY = 0;
  localparam int STAT_NACK = 1;
  localparam logic [1:0] PHASE_LAST = 2'h3;
  localparam logic [3:0] ACK_BIT = 4'h8;
endpackage

// *** charger_i2c_link_if.sv ***
// Purpose: two-wire link between bus master and charger target
// Assumes: both lines open-drain with pull-up; an enable low means driving
// Notes: wire levels are resolved here from the enables
interface charger_i2c_link_if;
  logic scl_out;
  logic scl_oe_n;
  logic host_sda_out;
  logic host_sda_oe_n;
  logic dev_sda_out;
  logic dev_sda_oe_n;
  logic scl;
  logic sda;

  assign scl = scl_oe_n | scl_out;
  assign sda = (host_sda_oe_n | host_sda_out) & (dev_sda_oe_n | dev_sda_out);

  modport host (output scl_out, output scl_oe_n, output host_sda_out,
                output host_sda_oe_n, input scl, input sda);
  modport target (output dev_sda_out, output dev_sda_oe_n, input scl, input sda);
endinterface

// *** charger_i2c_master.sv ***
// Purpose: byte-level two-wire bus master driven over APB
// Assumes: single master, no clock stretching by the target
// Notes: software sequences start, address, pointer, data and stop itself
module charger_i2c_master #(
  parameter int QUARTER = charger_i2c_pkg::QUARTER_CYCLES
) (
  input wire logic SYS_CLK_I,
  input wire logic RST_B_I,
  charger_i2c_link_if.host LINK,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [charger_i2c_pkg::APB_AW-1:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O
);
  import charger_i2c_pkg::*;

  typedef enum logic [1:0] {H_IDLE, H_START, H_BIT, H_STOP} host_state_e;

  // ---------------------------------------------------------------
  // sda sampling
  // ---------------------------------------------------------------
  logic [2:0] sda_sync_r;
  logic sda_f_r;
  always_ff @(posedge SYS_CLK_I) begin
    if (!RST_B_I) begin
      sda_sync_r <= 3'h7;
      sda_f_r <= 1'b1;
    end else begin
      sda_sync_r <= {sda_sync_r[1:0], LINK.sda};
      if (sda_sync_r[1] == sda_sync_r[2]) begin
        sda_f_r <= sda_sync_r[2];
      end
    end
  end

  // ---------------------------------------------------------------
  // APB registers
  // ---------------------------------------------------------------
  host_state_e state_r;
  logic [BYTE_W-1:0] tx_r;
  logic [BYTE_W-1:0] rx_r;
  logic do_start_r;
  logic do_stop_r;
  logic do_read_r;
  logic send_nack_r;
  logic nack_seen_r;
  logic [31:0] prdata_r;
  logic mapped;
  logic apb_wr;
  logic cmd_go;

  assign mapped = PADDR_I == CMD_OFS || PADDR_I == TXD_OFS
                  || PADDR_I == RXD_OFS || PADDR_I == STAT_OFS;
  assign apb_wr = PSEL_I & PENABLE_I & PWRITE_I & mapped;
  // commands written while a byte is in flight are dropped
  assign cmd_go = apb_wr && PADDR_I == CMD_OFS && state_r == H_IDLE;
  assign PREADY_O = 1'b1;
  assign PSLVERR_O = PSEL_I & PENABLE_I & ~mapped;
  assign PRDATA_O = prdata_r;

  always_ff @(posedge SYS_CLK_I) begin
    if (!RST_B_I) begin
      prdata_r <= 32'h0;
    end else if (PSEL_I && !PENABLE_I) begin
      prdata_r <= 32'h0;
      unique case (PADDR_I)
        TXD_OFS: prdata_r[BYTE_W-1:0] <= tx_r;
        RXD_OFS: prdata_r[BYTE_W-1:0] <= rx_r;
        STAT_OFS: begin
          prdata_r[STAT_BUSY] <= state_r != H_IDLE;
          prdata_r[STAT_NACK] <= nack_seen_r;
        end
        default: ;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // bit engine: four quarter phases per bit
  // ---------------------------------------------------------------
  logic [15:0] q_cnt_r;
  logic tick;
  logic [1:0] ph_r;
  logic [3:0] bit_r;
  logic scl_low_r;
  logic sda_low_r;

  assign tick = state_r != H_IDLE && q_cnt_r == 16'(QUARTER - 1);

  always_ff @(posedge SYS_CLK_I) begin
    if (!RST_B_I || state_r == H_IDLE || tick) begin
      q_cnt_r <= 16'h0;
    end else begin
      q_cnt_r <= q_cnt_r + 16'h1;
    end
  end

  always_ff @(posedge SYS_CLK_I) begin
    if (!RST_B_I) begin
      state_r <= H_IDLE;
      ph_r <= 2'h0;
      bit_r <= 4'h0;
      scl_low_r <= 1'b0;
      sda_low_r <= 1'b0;
      tx_r <= 8'h00;
      rx_r <= 8'h00;
      do_start_r <= 1'b0;
      do_stop_r <= 1'b0;
      do_read_r <= 1'b0;
      send_nack_r <= 1'b0;
      nack_seen_r <= 1'b0;
    end else if (state_r == H_IDLE) begin
      if (apb_wr && PADDR_I == TXD_OFS) begin
        tx_r <= PWDATA_I[BYTE_W-1:0];
      end
      if (cmd_go) begin
        do_start_r <= PWDATA_I[CMD_START];
        do_stop_r <= PWDATA_I[CMD_STOP];
        do_read_r <= PWDATA_I[CMD_READ];
        send_nack_r <= PWDATA_I[CMD_NACK];
        ph_r <= 2'h0;
        bit_r <= 4'h0;
        state_r <= PWDATA_I[CMD_START] ? H_START : H_BIT;
      end
    end else if (tick) begin
      ph_r <= ph_r + 2'h1;
      unique case (state_r)
        H_START: begin
          // works from idle and as a repeated start with scl low
          unique case (ph_r)
            2'h0: sda_low_r <= 1'b0;
            2'h1: scl_low_r <= 1'b0;
            2'h2: sda_low_r <= 1'b1;
            default: begin
              scl_low_r <= 1'b1;
              state_r <= H_BIT;
            end
          endcase
        end
        H_BIT: begin
          unique case (ph_r)
            2'h0: begin
              if (bit_r == ACK_BIT) begin
                sda_low_r <= do_read_r & ~send_nack_r;
              end else begin
                sda_low_r <= ~do_read_r & ~tx_r[BYTE_W-1];
              end
            end
            2'h1: scl_low_r <= 1'b0;
            2'h2: begin
              if (bit_r == ACK_BIT && !do_read_r) begin
                nack_seen_r <= sda_f_r;
              end else if (bit_r != ACK_BIT && do_read_r) begin
                rx_r <= {rx_r[BYTE_W-2:0], sda_f_r};
              end
            end
            default: begin
              scl_low_r <= 1'b1;
              bit_r <= bit_r + 4'h1;
              if (bit_r != ACK_BIT) begin
                tx_r <= {tx_r[BYTE_W-2:0], 1'b0};
              end else begin
                bit_r <= 4'h0;
                sda_low_r <= 1'b0;
                state_r <= do_stop_r ? H_STOP : H_IDLE;
              end
            end
          endcase
        end
        H_STOP: begin
          unique case (ph_r)
            2'h0: sda_low_r <= 1'b1;
            2'h1: scl_low_r <= 1'b0;
            2'h2: sda_low_r <= 1'b0;
            default: state_r <= H_IDLE;
          endcase
        end
        default: state_r <= H_IDLE;
      endcase
    end
  end

  assign LINK.scl_out = 1'b0;
  assign LINK.scl_oe_n = ~scl_low_r;
  assign LINK.host_sda_out = 1'b0;
  assign LINK.host_sda_oe_n = ~sda_low_r;
endmodule

// *** charger_i2c_register_port_properties.sv ***
// Purpose: wire checks on the link between the bus master and the charger target
// Assumes: QUARTER equals the master's; one clock domain
// Notes: byte tracking restarts at every start condition
module charger_i2c_register_port_properties
  import charger_i2c_pkg::*;
#(
  parameter int QUARTER = 8
) (
  input wire logic SYS_CLK_I,
  input wire logic RST_B_I,
  input wire logic host_sda_oe_n,
  input wire logic dev_sda_oe_n,
  input wire logic scl,
  input wire logic sda
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam int LOW_MAX = 40 * QUARTER;
  logic [3:0] bit_r;
  logic [7:0] shift_r;
  logic first_r;
  logic wsel_r;
  int low_r;
  default clocking cb @(posedge SYS_CLK_I); endclocking
  default disable iff (!RST_B_I);
  // ------------------------------------------------------------
  // helper state
  // ------------------------------------------------------------
  always_ff @(posedge SYS_CLK_I) begin
    if (!RST_B_I) begin
      bit_r <= 4'h0;
      first_r <= 1'b0;
      wsel_r <= 1'b0;
    end else if (scl && $fell(sda)) begin
      bit_r <= 4'h0;
      first_r <= 1'b1;
    end else if ($rose(scl) && bit_r == 4'h8) begin
      bit_r <= 4'h0;
      first_r <= 1'b0;
      if (first_r) begin
        wsel_r <= (shift_r[7:1] == TARGET_ADDR) && !shift_r[0];
      end
    end else if ($rose(scl)) begin
      bit_r <= bit_r + 4'h1;
      shift_r <= {shift_r[6:0], sda};
    end
  end
  // a held-low line longer than ten bit times means a stuck target
  always_ff @(posedge SYS_CLK_I) begin
    if (!RST_B_I || dev_sda_oe_n) begin
      low_r <= 0;
    end else begin
      low_r <= low_r + 1;
    end
  end
  addr_ack_a: assert property (
    $rose(scl) && bit_r == 4'h8 && first_r && shift_r[7:1] == TARGET_ADDR |-> !dev_sda_oe_n)
    else $error("own address not acknowledged");
  addr_refuse_a: assert property (
    $rose(scl) && bit_r == 4'h8 && first_r && shift_r[7:1] != TARGET_ADDR |-> dev_sda_oe_n)
    else $error("foreign address acknowledged");
  write_ack_a: assert property (
    $rose(scl) && bit_r == 4'h8 && !first_r && wsel_r |-> !dev_sda_oe_n)
    else $error("written byte not acknowledged");
  nack_release_a: assert property (
    $rose(scl) && bit_r == 4'h8 && !first_r && !wsel_r && sda |=> dev_sda_oe_n [*8])
    else $error("line not released after master nack");
  dev_edge_a: assert property (
    $changed(dev_sda_oe_n) |-> !scl && !$past(scl, 3))
    else $error("target moved data outside clock low");
  scl_high_a: assert property ($rose(scl) |-> scl [*8])
    else $error("clock high phase too short");
  sda_hold_a: assert property (
    scl && $past(scl) && $changed(sda) |-> $changed(host_sda_oe_n))
    else $error("data changed during clock high");
  byte_low_a: assert property (low_r <= LOW_MAX)
    else $error("target holds data low too long");
endmodule

// *** charger_i2c_register_port_tb_top.sv ***
// Purpose: bench joining the charger target and its APB bus master
// Assumes: QUARTER of 8 gives 32 clocks a bit
// Notes: every transfer is sequenced through the master's registers
module charger_i2c_register_port_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import charger_i2c_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic [3:0] paddr = 4'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, dis, llm, kick, boost, chg, stat_n;
  logic pin_n = 1'b1;
  logic user = 1'b0;
  logic det = 1'b0;
  logic wdr = 1'b0;
  logic [4:0] det_code = 5'h00;
  logic [1:0] sel;
  logic [4:0] icl;
  logic [2:0] smin;
  int err_total = 0;
  int comparisons = 0;
  charger_i2c_link_if link();
  charger_i2c_target i_charger_i2c_target (.SYS_CLK_I(clk), .RST_B_I(rst_n), .LINK(link),
    .CHARGE_ENABLE_PIN_N_I(pin_n), .STATUS_USER_I(user), .DETECT_DONE_I(det),
    .DETECT_ICL_CODE_I(det_code), .WATCHDOG_RESTART_I(wdr), .INPUT_DISCONNECT_ENABLE_O(dis),
    .STATUS_PIN_FUNCTION_SELECT_O(sel), .INPUT_CURRENT_LIMIT_CODE_O(icl),
    .LIGHT_LOAD_MODULATION_DISABLE_O(llm), .WATCHDOG_KICK_O(kick), .BOOST_OUTPUT_ENABLE_O(boost),
    .CHARGE_ACTIVE_O(chg), .MINIMUM_SYSTEM_VOLTAGE_CODE_O(smin), .STATUS_PIN_O(),
    .STATUS_PIN_OE_N_O(stat_n));
  charger_i2c_master #(.QUARTER(8)) i_charger_i2c_master (.SYS_CLK_I(clk), .RST_B_I(rst_n),
    .LINK(link), .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(paddr),
    .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr));
  charger_i2c_register_port_properties #(.QUARTER(8)) i_charger_i2c_register_port_properties (
    .SYS_CLK_I(clk), .RST_B_I(rst_n), .host_sda_oe_n(link.host_sda_oe_n),
    .dev_sda_oe_n(link.dev_sda_oe_n), .scl(link.scl), .sda(link.sda));
  initial forever #25 clk = ~clk;
  // ------------------------------------------------------------
  // bus and link tasks
  // ------------------------------------------------------------
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic apb(input logic w, input logic [3:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask
  task automatic xfer(input logic [3:0] c, input logic [7:0] tx, output logic [7:0] rx,
                      output logic nk);
    logic [31:0] q;
    logic e;
    apb(1'b1, TXD_OFS, {24'h0, tx}, q, e);
    apb(1'b1, CMD_OFS, {28'h0, c}, q, e);
    do begin
      apb(1'b0, STAT_OFS, 32'h0, q, e);
    end while (q[STAT_BUSY] !== 1'b0);
    nk = q[STAT_NACK];
    apb(1'b0, RXD_OFS, 32'h0, q, e);
    rx = q[7:0];
  endtask
  task automatic wr(input logic [7:0] p, input logic [7:0] d[$]);
    logic [7:0] rx;
    logic nk;
    xfer(4'h1, {7'h1A, 1'b0}, rx, nk);
    xfer(4'h0, p, rx, nk);
    foreach (d[i]) begin
      xfer((i == d.size() - 1) ? 4'h2 : 4'h0, d[i], rx, nk);
      chk("wr ack", 8'(nk), 8'h00);
    end
  endtask
  task automatic rd(input logic [7:0] p, input logic [7:0] e[$]);
    logic [7:0] rx;
    logic nk;
    xfer(4'h1, {7'h1A, 1'b0}, rx, nk);
    xfer(4'h0, p, rx, nk);
    xfer(4'h1, {7'h1A, 1'b1}, rx, nk);
    foreach (e[i]) begin
      xfer((i == e.size() - 1) ? 4'hE : 4'h4, 8'h00, rx, nk);
      chk("rd data", rx, e[i]);
    end
  endtask
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_reset();
    logic [31:0] q;
    logic e;
    chk("disc", 8'(dis), 8'h00);
    chk("sel", 8'(sel), 8'h00);
    chk("icl", 8'(icl), 8'h17);
    chk("llm", 8'(llm), 8'h00);
    chk("kick", 8'(kick), 8'h00);
    chk("boost", 8'(boost), 8'h00);
    chk("smin", 8'(smin), 8'h05);
    rd(8'h00, '{8'h17, 8'h1A});
    apb(1'b0, 4'h2, 32'h0, q, e);
    chk("slverr", 8'(e), 8'h01);
  endtask
  task automatic t_burst();
    wr(8'h08, '{8'hA1, 8'hA2, 8'hA3});
    rd(8'h0A, '{8'hA2, 8'hA3});
    wr(8'h0D, '{8'h5C, 8'hC5});
    rd(8'h0D, '{8'h5C, 8'hC5, 8'hFF});
  endtask
  task automatic t_ctrl();
    user <= 1'b1;
    wr(8'h00, '{8'hD5, 8'hFE});
    chk("disc", 8'(dis), 8'h01);
    chk("icl", 8'(icl), 8'h15);
    chk("float", 8'(stat_n), 8'h01);
    chk("llm", 8'(llm), 8'h01);
    chk("boost", 8'(boost), 8'h01);
    pin_n <= 1'b0;
    repeat (8) @(posedge clk);
    chk("boost wins", 8'(chg), 8'h00);
    chk("smin", 8'(smin), 8'h07);
    chk("kick", 8'(kick), 8'h01);
    wdr <= 1'b1;
    @(posedge clk);
    wdr <= 1'b0;
    repeat (8) @(posedge clk);
    chk("kick clr", 8'(kick), 8'h00);
  endtask
  task automatic t_charge();
    wr(8'h00, '{8'h37, 8'h1A});
    repeat (8) @(posedge clk);
    chk("chg", 8'(chg), 8'h01);
    chk("user", 8'(stat_n), 8'h00);
    pin_n <= 1'b1;
    repeat (8) @(posedge clk);
    chk("pin off", 8'(chg), 8'h00);
    det_code <= 5'h03;
    det <= 1'b1;
    @(posedge clk);
    det <= 1'b0;
    repeat (8) @(posedge clk);
    chk("detect", 8'(icl), 8'h03);
    wr(8'h00, '{8'h01});
    pin_n <= 1'b0;
    repeat (8) @(posedge clk);
    chk("host icl", 8'(icl), 8'h01);
    chk("follow", 8'(stat_n), 8'h00);
  endtask
  task automatic t_addr();
    logic [7:0] rx;
    logic nk;
    xfer(4'h3, {7'h1B, 1'b0}, rx, nk);
    chk("foreign", 8'(nk), 8'h01);
    xfer(4'h3, {7'h1A, 1'b0}, rx, nk);
    chk("own", 8'(nk), 8'h00);
  endtask
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    t_reset();
    t_burst();
    t_ctrl();
    t_charge();
    t_addr();
    close_out();
  end
  initial begin
    #3000000;
    err_total++;
    close_out();
  end
endmodule
